// ---- core/pad_decode.sv ----
// Purpose: address latch, memory and port decode, interrupt routing and port pins
// Assumes: processor pins are asynchronous and pass a three-stage synchroniser
// Notes:   registers reached over APB with one access wait-free answer
// What this block does
// - bank_select_n low means data memory, high program memory; gates all decodes.
// - address space is 16 address bits plus bank bit, 128K locations.
// - low address byte latched from multiplexed bus, held for the cycle.
// - whole program bank selects the 64Kx8 firmware memory.
// - upper half of data memory selects the 32Kx8 battery-backed RAM.
// - battery RAM chip select forced inactive while reset is asserted.
// - lowest data quarter gives port strobes; second quarter selects display memory.
// - buffered I/O bus enabled only for the lower half of data memory.
// - interrupt inputs: conversion, stop, instrument bus, 1 kHz tick, start, dropout.
// - two 16-bit tap counters raise an interrupt on each overflow.
// - processor clock enable divided down from the single 250 MHz clock, just above 20 MHz.
// - active-low reload output pin only; the internal tap counters are not reloaded by it.
// - active-low bus request output plus printer, serial and stop-enable pins.
`timescale 1ns/1ps

module pad_decode
    import pad_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire pad_pins_t     pins,
    output pad_mem_sel_t       mem_sel,
    output pad_port_out_t      port_out,
    output logic [7:0]         cpu_irq_n,
    output logic               cpu_clk_en,
    output logic               cpu_serial_rx
);

    pad_state_t q;
    pad_state_t n;
    logic       tick_rise;
    logic       cyc_rise;
    logic       data_bank;
    logic [7:0] port_strobe_sel;

    // next state: synchroniser, address latch, counters, registers, divider
    always_comb
    begin
        pad_pins_t old;
        pad_pins_t nw;
        pad_pins_t diff;
        n    = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        // a change counts only once stages two and three agree
        diff   = pad_pins_t'(q.s2 ^ q.s3);
        n.stab = pad_pins_t'((~diff & q.s3) | (diff & q.stab));
        old    = q.stab;
        nw     = n.stab;

        if (old.as_n && !nw.as_n)
        begin
            n.addr_lo = nw.ad;
            n.addr_hi = nw.addr_hi;
            n.bank    = nw.bank_select_n;
            n.active  = 1'b1;
        end
        else if (!old.ds_n && nw.ds_n)
        begin
            n.active = 1'b0;            // cycle ends with the data strobe
        end

        // register access: prepare read data in the setup cycle
        if (psel && !penable)
        begin
            n.slverr = 1'b0;
            if (paddr == OFS_CTRL)
            begin
                n.rdata = {27'h0, q.ctrl};
            end
            else if (paddr == OFS_STATUS)
            begin
                n.rdata = {26'h0, q.stab.serial_rx_line, q.stab.prn_busy,
                           q.bank, q.active, q.ovf};
            end
            else if (paddr == OFS_COUNT)
            begin
                n.rdata = {q.cyc_cnt, q.tick_cnt};
            end
            else
            begin
                n.rdata  = 32'h0;
                n.slverr = 1'b1;        // unmapped address answers with an error
            end
        end

        // software writes drive the dedicated port pins and clear the overflow flags
        if (psel && penable && pwrite && !q.slverr)
        begin
            if (paddr == OFS_CTRL)
            begin
                n.ctrl = pwdata[4:0];
            end
            else if (paddr == OFS_STATUS)
            begin
                n.ovf = q.ovf & ~pwdata[1:0];   // write one to clear
            end
        end

        // tap counters, overflow sets after the clear so set wins
        tick_rise = !old.ticks_tap && nw.ticks_tap;
        cyc_rise  = !old.cycles_tap && nw.cycles_tap;
        if (tick_rise)
        begin
            n.tick_cnt = q.tick_cnt + 16'h0001;
            if (q.tick_cnt == CNT_FULL)
            begin
                n.ovf[0] = 1'b1;
            end
        end
        if (cyc_rise)
        begin
            n.cyc_cnt = q.cyc_cnt + 16'h0001;
            if (q.cyc_cnt == CNT_FULL)
            begin
                n.ovf[1] = 1'b1;
            end
        end

        // processor clock enable, independent of measurement timing
        if (q.div == CPU_DIV_LAST)
        begin
            n.div    = 4'h0;
            n.cpu_en = 1'b1;
        end
        else
        begin
            n.div    = q.div + 4'h1;
            n.cpu_en = 1'b0;
        end

        // interrupt routing, overflow flags held low until cleared
        n.irq_n = {~q.ovf[1], nw.dropout_n, nw.start_rcvd_n, ~q.ovf[0],
                   nw.rtc_tick_n, nw.gpib_int_n, nw.stop_rcvd_n, nw.adc_done_n};
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            q <= STATE_RST;
        end
        else
        begin
            q <= n;
        end
    end

    // decode only while a latched cycle is active, per bank
    assign data_bank = q.active && !q.bank;

    // decoded selects from latched address
    always_comb
    begin
        // unmatched regions leave every select inactive
        mem_sel         = '0;
        mem_sel.addr_lo = q.addr_lo;
        // program bank is entirely firmware memory
        mem_sel.rom_cs_n  = !(q.active && q.bank);
        // upper data half, blocked during reset so power-down is safe
        mem_sel.sram_cs_n = !(data_bank && q.addr_hi[7] && !rst);
        mem_sel.disp_cs_n = !(data_bank && q.addr_hi[7:6] == 2'b01);
        // buffered port bus only for the lower data half
        mem_sel.io_buf_en = data_bank && !q.addr_hi[7];
        mem_sel.io_buf_rd = data_bank && !q.addr_hi[7] && q.stab.rw_n;
        mem_sel.io_strobe_n = ~port_strobe_sel;
    end

    // one port strobe per eighth of the lowest quarter, during data strobe
    for (genvar i = 0; i < 8; i++)
    begin : g_strobe
        assign port_strobe_sel[i] = data_bank && !q.stab.ds_n
                                    && q.addr_hi[7:6] == 2'b00 && q.addr_hi[5:3] == 3'(i);
    end

    // dedicated port pins, active-low ones inverted from the control bits
    assign port_out.reload_n       = !q.ctrl[CTRL_RELOAD];
    assign port_out.busrq_n        = !q.ctrl[CTRL_BUSRQ];
    assign port_out.prnt_stb_n     = !q.ctrl[CTRL_PRNT_STB];
    assign port_out.stop_in_en_n   = !q.ctrl[CTRL_STOP_EN];
    assign port_out.serial_tx_line = q.ctrl[CTRL_TX];

    // processor-facing outputs
    assign cpu_irq_n     = q.irq_n;
    assign cpu_clk_en    = q.cpu_en;
    assign cpu_serial_rx = q.stab.serial_rx_line;

    // APB answer: always ready in the access phase, data prepared at setup
    assign pready  = psel && penable;
    assign prdata  = q.rdata;
    assign pslverr = psel && penable && q.slverr;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_rom_bank: assert property (!mem_sel.rom_cs_n |-> q.bank && q.active)
        else $error("firmware selected outside program bank");
    a_space_width: assert property (q.active |-> (SPACE_WORDS == 131072))
        else $error("address space size wrong");
    a_addr_hold: assert property (q.active && $past(q.active) |-> $stable(q.addr_lo))
        else $error("latched address changed mid cycle");
    a_sram_half: assert property (!mem_sel.sram_cs_n |-> !q.bank && q.addr_hi[7])
        else $error("battery ram selected outside upper data half");
    a_sram_reset: assert property (@(posedge clock) disable iff (1'b0)
        rst |-> mem_sel.sram_cs_n)
        else $error("battery ram selected during reset");
    a_disp_quarter: assert property (!mem_sel.disp_cs_n |-> mem_sel.io_buf_en
        && q.addr_hi[6])
        else $error("display select outside second quarter");
    a_strobe_quarter: assert property (mem_sel.io_strobe_n != 8'hFF
        |-> !q.bank && q.addr_hi[7:6] == 2'b00 && !q.stab.ds_n)
        else $error("port strobe outside lowest quarter");
    a_buf_upper: assert property (q.active && !q.bank && q.addr_hi[7]
        |-> !mem_sel.io_buf_en && mem_sel.io_strobe_n == 8'hFF)
        else $error("port bus enabled for upper data half");
    a_irq_rtc: assert property ($fell(q.stab.rtc_tick_n) |=> !cpu_irq_n[3])
        else $error("tick interrupt not routed");
    a_ovf_irq: assert property (tick_rise && q.tick_cnt == CNT_FULL
        |=> q.ovf[0] ##1 !cpu_irq_n[4])
        else $error("tick counter overflow lost");
    a_cpu_rate: assert property (cpu_clk_en |=> !cpu_clk_en [*8])
        else $error("processor clock enable too fast");
    a_reload_pin: assert property (psel && penable && pwrite && paddr == OFS_CTRL
        && !q.slverr && pwdata[CTRL_RELOAD] |=> !port_out.reload_n)
        else $error("reload pin not asserted after write");
    a_one_select: assert property ($onehot0({!mem_sel.rom_cs_n, !mem_sel.sram_cs_n,
        !mem_sel.disp_cs_n}))
        else $error("two memories selected at once");

endmodule

// ---- core/pad_pkg.sv ----
// Purpose: shared constants and types for the processor address decode glue
// Assumes: one 250 MHz clock, synchronous active-high reset, APB register access
// Notes:   pin groups travel as packed structs; all module state is one struct
package pad_pkg;

    // clock and derived processor clock enable
    localparam int unsigned CLK_FREQ_HZ   = 250_000_000;
    localparam int unsigned CPU_TARGET_HZ = 20_000_000;
    // integer division rounds down, so the enable rate lands just above target
    localparam int unsigned CPU_DIV       = CLK_FREQ_HZ / CPU_TARGET_HZ;
    localparam logic [3:0]  CPU_DIV_LAST  = 4'(CPU_DIV - 1);
    // fastest counter tap the far side may present
    localparam int unsigned TAP_MAX_HZ    = 1_500_000;

    // address space: 16 address bits plus one bank bit
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned SPACE_WORDS   = 2 ** (ADDR_W + 1);
    localparam logic [15:0] CNT_FULL      = 16'hFFFF;

    // register byte offsets
    localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS    = 32'h0000_0004;
    localparam logic [31:0] OFS_COUNT     = 32'h0000_0008;

    // control register fields
    localparam int unsigned CTRL_RELOAD   = 0;
    localparam int unsigned CTRL_BUSRQ    = 1;
    localparam int unsigned CTRL_PRNT_STB = 2;
    localparam int unsigned CTRL_STOP_EN  = 3;
    localparam int unsigned CTRL_TX       = 4;
    localparam logic [4:0]  CTRL_RST      = 5'h10;

    // pins arriving from the processor and the instrument
    typedef struct packed {
        logic [7:0] ad;
        logic [7:0] addr_hi;
        logic       as_n;
        logic       ds_n;
        logic       rw_n;
        logic       bank_select_n;
        logic       ticks_tap;
        logic       cycles_tap;
        logic       adc_done_n;
        logic       stop_rcvd_n;
        logic       gpib_int_n;
        logic       rtc_tick_n;
        logic       start_rcvd_n;
        logic       dropout_n;
        logic       prn_busy;
        logic       serial_rx_line;
    } pad_pins_t;

    localparam pad_pins_t PINS_IDLE = '{as_n: 1'b1, ds_n: 1'b1, rw_n: 1'b1,
        bank_select_n: 1'b1, adc_done_n: 1'b1, stop_rcvd_n: 1'b1, gpib_int_n: 1'b1,
        rtc_tick_n: 1'b1, start_rcvd_n: 1'b1, dropout_n: 1'b1,
        serial_rx_line: 1'b1, default: '0};

    // chip selects and strobes toward memories and ports
    typedef struct packed {
        logic       rom_cs_n;
        logic       sram_cs_n;
        logic       disp_cs_n;
        logic       io_buf_en;
        logic       io_buf_rd;
        logic [7:0] io_strobe_n;
        logic [7:0] addr_lo;
    } pad_mem_sel_t;

    // dedicated port pins
    typedef struct packed {
        logic reload_n;
        logic busrq_n;
        logic prnt_stb_n;
        logic stop_in_en_n;
        logic serial_tx_line;
    } pad_port_out_t;

    typedef struct packed {
        pad_pins_t   s1;
        pad_pins_t   s2;
        pad_pins_t   s3;
        pad_pins_t   stab;
        logic [7:0]  addr_lo;
        logic [7:0]  addr_hi;
        logic        bank;
        logic        active;
        logic [15:0] tick_cnt;
        logic [15:0] cyc_cnt;
        logic [1:0]  ovf;
        logic [4:0]  ctrl;
        logic [31:0] rdata;
        logic        slverr;
        logic [3:0]  div;
        logic        cpu_en;
        logic [7:0]  irq_n;
    } pad_state_t;

    localparam pad_state_t STATE_RST = '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE,
        stab: PINS_IDLE, bank: 1'b1, ctrl: CTRL_RST, irq_n: 8'hFF, default: '0};

endpackage

// ---- tb/pad_proc_model.sv ----
// Purpose: processor-side model that drives the pin bundle of the decoder
// Assumes: address strobe phase first, then a data strobe phase
// Notes:   released address lines show the inverse of the last byte
`timescale 1ns/1ps

module pad_proc_model
    import pad_pkg::*;
(
    input  wire logic clock,
    output pad_pins_t pins
);
    initial pins = PINS_IDLE;

    // bank bit set with the address and held through the cycle
    task automatic bus_start(input logic bank, input logic [15:0] a);
        pins.bank_select_n <= bank;
        pins.addr_hi       <= a[15:8];
        pins.ad            <= a[7:0];
        pins.as_n          <= 1'b0;
        repeat (2) @(posedge clock);
        // the muxed bus no longer carries the address byte
        pins.as_n          <= 1'b1;
        pins.ad            <= ~a[7:0];
        pins.ds_n          <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    // data strobe rise ends the cycle
    task automatic bus_end();
        pins.ds_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // 168-clock period keeps the taps below 1.5 MHz
    task automatic tap(input int which, input int n);
        repeat (n)
        begin
            if (which == 0) pins.ticks_tap <= 1'b1;
            else pins.cycles_tap <= 1'b1;
            repeat (84) @(posedge clock);
            pins.ticks_tap  <= 1'b0;
            pins.cycles_tap <= 1'b0;
            repeat (84) @(posedge clock);
        end
    endtask

    // interrupt sources, low active
    task automatic irq(input int k, input logic v);
        case (k)
            0: pins.adc_done_n   <= v;
            1: pins.stop_rcvd_n  <= v;
            2: pins.gpib_int_n   <= v;
            3: pins.rtc_tick_n   <= v;
            4: pins.start_rcvd_n <= v;
            default: pins.dropout_n <= v;
        endcase
    endtask
endmodule

// ---- tb/tb_processor_address_decode.sv ----
// Purpose: self-checking bench for the address decode glue
// Assumes: zero-wait APB slave, pins pass a three-stage synchroniser
// Notes:   drivers queue notes, one monitor pops and compares them
`timescale 1ns/1ps

module tb_processor_address_decode;
    import pad_pkg::*;
    typedef struct packed {
        logic [2:0]  k;
        logic [32:0] e;
    } pad_note_t;
    logic          clock = 1'b0;
    logic          rst = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [31:0]   paddr = '0;
    logic [31:0]   pwdata = '0;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    pad_pins_t     pins;
    pad_mem_sel_t  mem_sel;
    pad_port_out_t port_out;
    logic [7:0]    cpu_irq_n;
    logic          cpu_clk_en;
    logic          go = 1'b0;
    logic          rd_on = 1'b0;
    logic [7:0]    meas = '0;
    logic [7:0]    gap = '0;
    logic [32:0]   act;
    logic [4:0]    v;
    logic          b;
    logic [15:0]   a;
    pad_note_t     nt;
    pad_note_t     exp_q[$];
    int            i;
    int            c;
    int            n_fail = 0;
    int            tests_run = 0;
    int            irq_bit[6] = '{0, 1, 2, 3, 5, 6};

    always #2 clock = ~clock;

    pad_decode i_pad_decode (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pins(pins), .mem_sel(mem_sel),
        .port_out(port_out), .cpu_irq_n(cpu_irq_n), .cpu_clk_en(cpu_clk_en),
        .cpu_serial_rx());
    pad_proc_model i_pad_proc_model (.clock(clock), .pins(pins));

    // expected selects: rom for program bank, sram upper half, display, ports
    function automatic logic [19:0] exp_sel(input logic bk, input logic [15:0] ad,
                                            input logic on);
        logic d;
        d = on & ~bk;
        return {~(on & bk), ~(d & ad[15]), ~(d & ad[15:14] == 2'b01), d & ~ad[15],
                ~(8'(d & ad[15:14] == 2'b00) << ad[13:11]), ad[7:0]};
    endfunction

    // gap between clock-enable pulses, sampled at the edge to avoid races
    always @(posedge clock)
    begin
        if (cpu_clk_en === 1'b1)
        begin
            meas <= gap;
            gap  <= 8'h01;
        end
        else gap <= gap + 8'h01;
    end

    // monitor: oldest note against what the outputs show
    always @(posedge clock)
    begin
        if (go === 1'b1 || (rd_on === 1'b1 && pready === 1'b1))
        begin
            nt = exp_q.pop_front();
            case (nt.k)
                0: act = {pslverr, prdata};
                1: act = 33'({mem_sel.rom_cs_n, mem_sel.sram_cs_n, mem_sel.disp_cs_n,
                    mem_sel.io_buf_en, mem_sel.io_strobe_n, mem_sel.addr_lo});
                2: act = 33'(port_out);
                3: act = 33'(cpu_irq_n);
                4: act = 33'(mem_sel.sram_cs_n);
                default: act = 33'(meas);
            endcase
            tests_run++;
            if (act !== nt.e)
            begin
                $display("mismatch %0t kind %0d exp %h got %h", $time, nt.k, nt.e, act);
                n_fail++;
            end
        end
    end

    task automatic note(input logic [2:0] k, input logic [32:0] e);
        exp_q.push_back('{k, e});
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
    endtask

    // one APB transfer; a read queues its expected {pslverr, prdata}
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d,
                       input logic [32:0] e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        if (!w) exp_q.push_back('{3'd0, e});
        rd_on <= ~w;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
        rd_on   <= 1'b0;
        @(posedge clock);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #100000;
        n_fail++;
        $display("mismatch %0t watchdog expired", $time);
        conclude();
    end

    // main sequence
    initial
    begin
        v = 5'($urandom(80));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, OFS_CTRL, '0, 33'(CTRL_RST));
        apb(1'b0, OFS_STATUS, '0, 33'(32'h0000_0028));
        note(2, 33'(5'h1F));
        note(3, 33'(8'hFF));
        apb(1'b0, 32'h0000_000C, '0, {1'b1, 32'h0});
        for (i = 0; i < 6; i++)
        begin
            v = (i < 5) ? 5'(1 << i) : 5'($urandom);
            apb(1'b1, OFS_CTRL, 32'(v), '0);
            note(2, 33'({~v[0], ~v[1], ~v[2], ~v[3], v[4]}));
            apb(1'b0, OFS_CTRL, '0, 33'(v));
        end
        for (i = 0; i < 10; i++)
        begin
            b = (i % 5 == 0);
            a = {2'(i % 4), 14'($urandom)};
            i_pad_proc_model.bus_start(b, a);
            note(1, 33'(exp_sel(b, a, 1'b1)));
            i_pad_proc_model.bus_end();
            note(1, 33'(exp_sel(b, a, 1'b0)));
        end
        i_pad_proc_model.bus_start(1'b0, 16'hC000 | 16'($urandom & 16'h3FFF));
        rst <= 1'b1;
        note(4, 33'h1);
        rst <= 1'b0;
        i_pad_proc_model.bus_end();
        for (i = 0; i < 6; i++)
        begin
            i_pad_proc_model.irq(i, 1'b0);
            repeat (6) @(posedge clock);
            note(3, 33'(8'(~(8'h01 << irq_bit[i]))));
            i_pad_proc_model.irq(i, 1'b1);
            repeat (6) @(posedge clock);
        end
        i_pad_proc_model.tap(0, 3);
        i_pad_proc_model.tap(1, 2);
        apb(1'b0, OFS_COUNT, '0, {1'b0, 16'd2, 16'd3});
        note(6, 33'(CPU_DIV));
        conclude();
    end
endmodule
